// [display_rotation_pkg.sv]
// constants and types shared by the main-window rotation fetch block
package display_rotation_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFF_DISPLAY_SETTINGS = 8'h10;
  localparam logic [7:0] OFF_MAIN_START = 8'h40;
  localparam logic [7:0] OFF_MAIN_LINE_OFFSET = 8'h44;
  localparam logic [7:0] OFF_PANEL_SIZE = 8'h48;
  localparam logic [7:0] OFF_SCAN_STATUS = 8'h4C;

  // ==========================================================
  // field layout
  localparam logic [31:0] DISPLAY_SETTINGS_MASK = 32'h03DB_0007;
  localparam int unsigned ROT_LSB = 16;
  localparam int unsigned BPP_LSB = 0;
  localparam int unsigned START_W = 16;
  localparam int unsigned LINE_OFF_W = 10;
  localparam int unsigned DIM_W = 10;
  localparam int unsigned PANEL_WIDTH_LSB = 0;
  localparam int unsigned PANEL_HEIGHT_LSB = 16;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_LAST_BIT = 1;
  localparam int unsigned STATUS_ROW_LSB = 16;
  localparam int unsigned PIX_IDX_W = 5;

  // ==========================================================
  // values after reset
  localparam logic [31:0] DISPLAY_SETTINGS_RST = 32'h0000_0000;
  localparam logic [15:0] MAIN_START_RST = 16'h0000;
  localparam logic [9:0] LINE_OFF_RST = 10'h000;
  localparam logic [9:0] PANEL_WIDTH_RST = 10'h140;
  localparam logic [9:0] PANEL_HEIGHT_RST = 10'h0F0;

  // ==========================================================
  // colour depth codes in the low bits of display settings
  localparam logic [2:0] BPP_1 = 3'h0;
  localparam logic [2:0] BPP_2 = 3'h1;
  localparam logic [2:0] BPP_4 = 3'h2;
  localparam logic [2:0] BPP_8 = 3'h3;
  localparam logic [2:0] BPP_16 = 3'h4;

  typedef enum logic [1:0] {
    ROT_0   = 2'b00,
    ROT_90  = 2'b01,
    ROT_180 = 2'b10,
    ROT_270 = 2'b11
  } rotation_t;

  typedef enum logic {
    SCAN_IDLE = 1'b0,
    SCAN_RUN  = 1'b1
  } scan_state_t;

endpackage

// [scan_axis.sv]
// position counter for one axis of the panel scan
module scan_axis
  import display_rotation_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic step,
  input wire logic [DIM_W-1:0] limit,
  output logic [DIM_W-1:0] pos,
  output logic last
);

  // ==========================================================
  // counter
  logic [DIM_W-1:0] pos_ff;
  logic [DIM_W-1:0] nxt_pos;

  assign last = (pos_ff == limit);
  assign nxt_pos = clr ? '0 :
                   (step & last) ? '0 :
                   step ? DIM_W'(pos_ff + 1'b1) : pos_ff;
  assign pos = pos_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_ff <= '0;
    end else if (ce) begin
      pos_ff <= nxt_pos;
    end
  end

endmodule

// [stride_accum.sv]
// running product of steps and line offset, built by repeated adds
module stride_accum
  import display_rotation_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic step,
  input wire logic [LINE_OFF_W-1:0] inc,
  output logic [START_W-1:0] sum
);

  // ==========================================================
  // accumulator
  logic [START_W-1:0] sum_ff;
  logic [START_W-1:0] nxt_sum;

  // wraps modulo the buffer address width; valid settings never wrap
  assign nxt_sum = clr ? '0 :
                   step ? START_W'(sum_ff + START_W'(inc)) : sum_ff;
  assign sum = sum_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_ff <= '0;
    end else if (ce) begin
      sum_ff <= nxt_sum;
    end
  end

endmodule

// [display_rotation_addressing.sv]
// main-window rotation and display-buffer fetch addressing, APB slave
//
// Notes on behaviour
// - selector bits 17-16: 0, 90, 180, 270
// - rotate counter-clockwise; 90/270 swap axes
// - all rotations at 1,2,4,8,16 bpp
// - start address is dword; zero is buffer start
// - line offset bits 9-0 in dwords
// - line offset equals stride in dwords
// - fetch visible part, step full offset
// - start address register at 40h
// - line offset register at 44h
//
// Implementation choice: the APB interface to the registers.
module display_rotation_addressing
  import display_rotation_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_start,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [START_W-1:0] fetch_addr,
  output logic [PIX_IDX_W-1:0] fetch_pixel,
  output logic fetch_last
);

  // ==========================================================
  // decode helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == OFF_DISPLAY_SETTINGS) || (a == OFF_MAIN_START) ||
                (a == OFF_MAIN_LINE_OFFSET) || (a == OFF_PANEL_SIZE) ||
                (a == OFF_SCAN_STATUS);
  endfunction

  // log2 of pixels per dword; unknown depth codes fetch as 16 bpp
  function automatic logic [2:0] pix_shift(input logic [2:0] code);
    unique case (code)
      BPP_1: pix_shift = 3'h5;
      BPP_2: pix_shift = 3'h4;
      BPP_4: pix_shift = 3'h3;
      BPP_8: pix_shift = 3'h2;
      BPP_16: pix_shift = 3'h1;
      default: pix_shift = 3'h1;
    endcase
  endfunction

  // ==========================================================
  // software registers
  logic [31:0] settings_ff;
  logic [START_W-1:0] start_ff;
  logic [LINE_OFF_W-1:0] line_off_ff;
  logic [DIM_W-1:0] panel_w_ff;
  logic [DIM_W-1:0] panel_h_ff;

  // ==========================================================
  // APB slave: one wait state, answer registered
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [31:0] rd_word;
  logic [31:0] status_word;

  wire [7:0] word_addr = {paddr[7:2], 2'b00};
  wire apb_access = psel & penable;
  wire apb_first = apb_access & ~pready_ff;
  wire apb_done = apb_access & pready_ff;
  wire addr_ok = is_mapped(word_addr);
  wire wr_en = apb_done & pwrite & addr_ok;
  wire wr_settings = wr_en & (word_addr == OFF_DISPLAY_SETTINGS);
  wire wr_start = wr_en & (word_addr == OFF_MAIN_START);
  wire wr_line_off = wr_en & (word_addr == OFF_MAIN_LINE_OFFSET);
  wire wr_panel = wr_en & (word_addr == OFF_PANEL_SIZE);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (word_addr)
      OFF_DISPLAY_SETTINGS: rd_word = settings_ff;
      OFF_MAIN_START: rd_word = {{(32-START_W){1'b0}}, start_ff};
      OFF_MAIN_LINE_OFFSET: rd_word = {{(32-LINE_OFF_W){1'b0}}, line_off_ff};
      OFF_PANEL_SIZE: begin
        rd_word[PANEL_WIDTH_LSB +: DIM_W] = panel_w_ff;
        rd_word[PANEL_HEIGHT_LSB +: DIM_W] = panel_h_ff;
      end
      OFF_SCAN_STATUS: rd_word = status_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= apb_first;
      pslverr_ff <= apb_first & ~addr_ok;
      if (apb_first & ~pwrite) begin
        prdata_ff <= rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settings_ff <= DISPLAY_SETTINGS_RST;
      start_ff <= MAIN_START_RST;
      line_off_ff <= LINE_OFF_RST;
      panel_w_ff <= PANEL_WIDTH_RST;
      panel_h_ff <= PANEL_HEIGHT_RST;
    end else if (ce) begin
      if (wr_settings) begin
        settings_ff <= pwdata & DISPLAY_SETTINGS_MASK;
      end
      if (wr_start) begin
        start_ff <= pwdata[START_W-1:0];
      end
      if (wr_line_off) begin
        line_off_ff <= pwdata[LINE_OFF_W-1:0];
      end
      if (wr_panel) begin
        panel_w_ff <= pwdata[PANEL_WIDTH_LSB +: DIM_W];
        panel_h_ff <= pwdata[PANEL_HEIGHT_LSB +: DIM_W];
      end
    end
  end

  // ==========================================================
  // frame shadow: a write mid-frame waits for the next frame
  rotation_t sh_rot_ff;
  logic [2:0] sh_shift_ff;
  logic [START_W-1:0] sh_start_ff;
  logic [LINE_OFF_W-1:0] sh_off_ff;
  logic [DIM_W-1:0] sh_w_ff;
  logic [DIM_W-1:0] sh_h_ff;

  wire [1:0] rot_field = settings_ff[ROT_LSB +: 2];
  wire [2:0] bpp_field = settings_ff[BPP_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_rot_ff <= ROT_0;
      sh_shift_ff <= 3'h1;
      sh_start_ff <= MAIN_START_RST;
      sh_off_ff <= LINE_OFF_RST;
      sh_w_ff <= PANEL_WIDTH_RST;
      sh_h_ff <= PANEL_HEIGHT_RST;
    end else if (ce & frame_start) begin
      sh_rot_ff <= rotation_t'(rot_field);
      sh_shift_ff <= pix_shift(bpp_field);
      sh_start_ff <= start_ff;
      sh_off_ff <= line_off_ff;
      sh_w_ff <= panel_w_ff;
      sh_h_ff <= panel_h_ff;
    end
  end

  // ==========================================================
  // scan of the panel: x along a panel row, y down the rows
  scan_state_t state_ff;
  scan_state_t nxt_state;
  logic fetch_valid_ff;
  logic fetch_last_ff;
  logic [START_W-1:0] fetch_addr_ff;
  logic [PIX_IDX_W-1:0] fetch_pixel_ff;
  logic [DIM_W-1:0] x_pos;
  logic [DIM_W-1:0] y_pos;
  logic x_last;
  logic y_last;
  logic [START_W-1:0] x_stride;
  logic [START_W-1:0] y_stride;

  // stall only while a fetch is offered and not taken
  wire advance = (state_ff == SCAN_RUN) & (~fetch_valid_ff | fetch_ready);
  wire row_end = advance & x_last;
  wire frame_end = row_end & y_last;

  scan_axis u_x_axis (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .clr(frame_start),
    .step(advance),
    .limit(DIM_W'(sh_w_ff - 1'b1)),
    .pos(x_pos),
    .last(x_last)
  );

  scan_axis u_y_axis (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .clr(frame_start),
    .step(row_end),
    .limit(DIM_W'(sh_h_ff - 1'b1)),
    .pos(y_pos),
    .last(y_last)
  );

  // x times offset, cleared at each row end
  stride_accum u_x_stride (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .clr(frame_start | row_end),
    .step(advance),
    .inc(sh_off_ff),
    .sum(x_stride)
  );

  // y times offset: rows step by the full programmed offset
  stride_accum u_y_stride (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .clr(frame_start),
    .step(row_end),
    .inc(sh_off_ff),
    .sum(y_stride)
  );

  // ==========================================================
  // address of the current pixel
  // the offset stands for the stride in dwords, so it is added as is
  wire [PIX_IDX_W-1:0] pix_mask = PIX_IDX_W'((6'h01 << sh_shift_ff) - 1'b1);
  wire [DIM_W-1:0] x_dword = x_pos >> sh_shift_ff;
  wire [DIM_W-1:0] y_dword = y_pos >> sh_shift_ff;
  wire [PIX_IDX_W-1:0] x_sub = x_pos[PIX_IDX_W-1:0] & pix_mask;
  wire [PIX_IDX_W-1:0] y_sub = y_pos[PIX_IDX_W-1:0] & pix_mask;
  wire [START_W-1:0] x_dw = START_W'(x_dword);
  wire [START_W-1:0] y_dw = START_W'(y_dword);
  logic [START_W-1:0] pix_addr;
  logic [PIX_IDX_W-1:0] pix_idx;

  always_comb begin
    pix_addr = sh_start_ff;
    pix_idx = x_sub;
    unique case (sh_rot_ff)
      ROT_0: begin
        pix_addr = START_W'(sh_start_ff + y_stride + x_dw);
        pix_idx = x_sub;
      end
      ROT_90: begin
        // start names the last dword of memory line 0
        pix_addr = START_W'(sh_start_ff + x_stride - y_dw);
        pix_idx = pix_mask ^ y_sub;
      end
      ROT_180: begin
        pix_addr = START_W'(sh_start_ff - y_stride - x_dw);
        pix_idx = pix_mask ^ x_sub;
      end
      ROT_270: begin
        pix_addr = START_W'(sh_start_ff - x_stride + y_dw);
        pix_idx = y_sub;
      end
    endcase
  end

  // ==========================================================
  // scan control and fetch outputs
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SCAN_IDLE: if (frame_start) nxt_state = SCAN_RUN;
      SCAN_RUN: begin
        if (frame_start) begin
          nxt_state = SCAN_RUN;
        end else if (frame_end) begin
          nxt_state = SCAN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SCAN_IDLE;
      fetch_valid_ff <= 1'b0;
      fetch_last_ff <= 1'b0;
      fetch_addr_ff <= '0;
      fetch_pixel_ff <= '0;
    end else if (ce) begin
      state_ff <= nxt_state;
      if (advance & ~frame_start) begin
        fetch_valid_ff <= 1'b1;
        fetch_last_ff <= frame_end;
        fetch_addr_ff <= pix_addr;
        fetch_pixel_ff <= pix_idx;
      end else if (fetch_valid_ff & fetch_ready) begin
        fetch_valid_ff <= 1'b0;
        fetch_last_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STATUS_BUSY_BIT] = (state_ff == SCAN_RUN);
    status_word[STATUS_LAST_BIT] = fetch_last_ff;
    status_word[STATUS_ROW_LSB +: DIM_W] = y_pos;
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fetch_valid = fetch_valid_ff;
  assign fetch_addr = fetch_addr_ff;
  assign fetch_pixel = fetch_pixel_ff;
  assign fetch_last = fetch_last_ff;

endmodule

// [display_rotation_sva.sv]
// concurrent checks on the rotation fetch block's ports
module display_rotation_sva
  import display_rotation_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_start,
  input wire logic fetch_ready,
  input wire logic fetch_valid,
  input wire logic [START_W-1:0] fetch_addr,
  input wire logic [PIX_IDX_W-1:0] fetch_pixel,
  input wire logic fetch_last
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // helpers
  wire logic [7:0] word_addr = {paddr[7:2], 2'b00};
  wire logic mapped = word_addr inside {OFF_DISPLAY_SETTINGS,
    OFF_MAIN_START, OFF_MAIN_LINE_OFFSET, OFF_PANEL_SIZE, OFF_SCAN_STATUS};
  wire logic taken = fetch_valid && fetch_ready && !frame_start && ce;
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  sequence s_fetch_start;
    !fetch_valid ##1 fetch_valid;
  endsequence
  // ==========================================================
  // register bus
  a_one_wait: assert property ($rose(penable) && psel && ce |-> s_one_wait)
    else $error("apb answer not after one wait state");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unmapped: assert property (pready && psel && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (pready && psel && mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_reset_idle: assert property ($rose(presetn) |->
    !fetch_valid && !pready && !pslverr)
    else $error("outputs busy right after reset");
  // ==========================================================
  // fetch stream
  a_fetch_hold: assert property (fetch_valid && !fetch_ready && ce |=>
    fetch_valid && $stable(fetch_addr) && $stable(fetch_pixel))
    else $error("offered fetch changed before acceptance");
  a_frame_start: assert property (frame_start && !fetch_valid && ce |=>
    s_fetch_start)
    else $error("first fetch not two edges after frame start");
  a_last_ends: assert property (taken && fetch_last |=> !fetch_valid)
    else $error("fetch offered after last of frame");
  a_full_rate: assert property (taken && !fetch_last |=> fetch_valid)
    else $error("fetch stream gap while memory ready");
endmodule

bind display_rotation_addressing display_rotation_sva u_sva (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .frame_start(frame_start), .fetch_ready(fetch_ready),
  .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
  .fetch_pixel(fetch_pixel), .fetch_last(fetch_last)
);

// [fetch_memory.sv]
// display buffer model: accepts fetches at full rate or every other cycle
module fetch_memory (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic fetch_valid,
  output logic fetch_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase_ff;
  // pace moves only while a fetch is offered; ready is not gated by valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 1'b0;
      fetch_ready <= 1'b0;
    end else begin
      phase_ff <= phase_ff ^ fetch_valid;
      fetch_ready <= !slow || phase_ff;
    end
  end
endmodule

// [display_rotation_addressing_tb.sv]
// testbench: register access and rotated fetch order of the main window
module display_rotation_addressing_tb;
  import display_rotation_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, ce, psel, penable, pwrite, frame_start, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, fetch_ready, fetch_valid, fetch_last, e;
  logic [START_W-1:0] fetch_addr;
  logic [PIX_IDX_W-1:0] fetch_pixel;
  logic [15:0] ea;
  logic [4:0] ep;
  int fails, checks_done, cyc, rot, ppd, s, off, px, py, nf, b, bp, st;
  localparam int W = 4;
  localparam int H = 3;
  localparam int BA = 256;
  display_rotation_addressing uut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_start(frame_start), .fetch_ready(fetch_ready),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_pixel(fetch_pixel), .fetch_last(fetch_last));
  fetch_memory mem (.pclk(pclk), .presetn(presetn), .slow(slow),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready));
  // ==========================================================
  // helpers
  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no assumed latency: a hang is ended by the cycle ceiling only
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(logic [7:0] a, logic [31:0] x, logic xe);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", x, q);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  // ==========================================================
  // fetch monitor: expected order and addresses per rotation
  always @(posedge pclk) begin
    if (presetn && fetch_valid === 1'b1 && fetch_ready === 1'b1) begin
      case (rot)
        0: begin ea = 16'(s + py * off + px / ppd); ep = 5'(px % ppd); end
        1: begin ea = 16'(s + px * off - py / ppd); ep = 5'(ppd-1-py % ppd); end
        2: begin ea = 16'(s - py * off - px / ppd); ep = 5'(ppd-1-px % ppd); end
        default: begin ea = 16'(s - px * off + py / ppd); ep = 5'(py % ppd); end
      endcase
      chk("fetch_addr", 32'(ea), 32'(fetch_addr));
      chk("fetch_pixel", 32'(ep), 32'(fetch_pixel));
      chk("fetch_last", 32'(px == W-1 && py == H-1), 32'(fetch_last));
      nf++;
      px++;
      if (px == W) begin
        px = 0;
        py++;
      end
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, frame_start, slow} = '0;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_DISPLAY_SETTINGS, 32'h0000_0000, 1'b0);
    rdc(OFF_MAIN_START, 32'h0000_0000, 1'b0);
    rdc(OFF_MAIN_LINE_OFFSET, 32'h0000_0000, 1'b0);
    rdc(OFF_PANEL_SIZE, 32'h00F0_0140, 1'b0);
    rdc(8'h20, 32'h0000_0000, 1'b1);
    apb(1'b1, OFF_MAIN_LINE_OFFSET, 32'hFFFF_FFFF);
    rdc(OFF_MAIN_LINE_OFFSET, 32'h0000_03FF, 1'b0);
    apb(1'b1, OFF_DISPLAY_SETTINGS, 32'hFFFF_FFFF);
    rdc(OFF_DISPLAY_SETTINGS, 32'h03DB_0007, 1'b0);
    apb(1'b1, OFF_PANEL_SIZE, 32'h0003_0004);
    for (int c = 0; c < 5; c++) begin
      for (int r = 0; r < 4; r++) begin
        bp = 1 << c;
        ppd = 32 >> c;
        st = 4 * bp;
        off = 32 / ppd;
        b = ((r == 1) ? H : W) * bp / 8;
        case (r)
          0: s = BA / 4;
          1: s = (BA + b + ((4 - b) & 3)) / 4 - 1;
          2: s = (BA + st * (H - 1) + b + ((4 - b) & 3)) / 4 - 1;
          default: s = (BA + (W - 1) * st) / 4;
        endcase
        apb(1'b1, OFF_DISPLAY_SETTINGS, 32'(r << 16 | c));
        apb(1'b1, OFF_MAIN_START, 32'(s));
        apb(1'b1, OFF_MAIN_LINE_OFFSET, 32'(off));
        rot = r;
        nf = 0;
        px = 0;
        py = 0;
        slow <= c[0];
        @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        // a mid-frame change must wait for the next frame
        if (r == 2) apb(1'b1, OFF_MAIN_START, 32'h0000_1234);
        for (int i = 0; i < 200 && nf < W * H; i++) @(posedge pclk);
        chk("fetch count", 32'(W * H), 32'(nf));
      end
    end
    rdc(OFF_SCAN_STATUS, 32'h0000_0000, 1'b0);
    end_sim();
  end
endmodule
